// file: rtl/usb_pkg.sv
// constants for the serial transceiver status, buffering and interrupt block
// assumes one 100 MHz clock and a 16x baud tick made on that same clock
package usb_pkg;
	// register select on the two address pins
	localparam logic [1:0] ADDR_HOLDING = 2'h0; // receive read, transmit write
	localparam logic [1:0] ADDR_LINE_STATUS = 2'h1;
	localparam logic [1:0] ADDR_MODEM_STATUS = 2'h3;
	// line_status field positions
	localparam int ST_PARITY = 0;
	localparam int ST_FRAMING = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_BREAK = 3;
	localparam int ST_MODEM = 4;
	localparam int ST_DONE = 5;
	localparam int ST_TBE = 6;
	localparam int ST_READY = 7;
	// modem_line_status field positions
	localparam int MS_CTS = 0;
	localparam int MS_DSR = 1;
	// reset values
	localparam logic [7:0] LINE_STATUS_RST = 8'h60;
	localparam logic [7:0] EDGE_LATCH_RST = 8'h20;
	// flags that may raise the interrupt without the modem mask
	localparam logic [7:0] IRQ_PLAIN_MASK = 8'h2f;
	// bit timing in baud ticks
	localparam logic [3:0] TICKS_HALF = 4'h7;
	localparam logic [3:0] TICKS_LAST = 4'hf;
	localparam int RX_FIFO_DEPTH = 16;
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT_HIGH
	} usb_rx_state_t;
endpackage

// file: rtl/usb_core.sv
// status, receive/transmit buffering and interrupt logic of the transceiver
// assumes host pins (select, strobes, address, data) and modem pins arrive
// asynchronously and are synchronised here; format and enables are inputs
// driven by control logic on this clock; baud_tick pulses 16x the bit rate
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// receive queue between the receive shift register and receive holding
module usb_fifo
	import usb_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = RX_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q;
	logic push, pop;

	// honest flags from the fill count
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_q];

	// storage has no reset; only written words are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // usb_fifo

////////////////////////////////////////////////////////////////////////////////
module usb_core
	import usb_pkg::*;
#(
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// host bus pins, all low true except address, data and data_oe
	input wire logic cs_b,
	input wire logic rd_b,
	input wire logic wr_b,
	input wire logic [1:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// request pins and interrupt
	output logic rx_data_ready,
	output logic tx_holding_empty,
	output logic irq_out,
	// serial and modem pins
	input wire logic serial_in,
	output logic serial_out,
	input wire logic cts_b,
	input wire logic dsr_b,
	// format and enables from control logic
	input wire logic baud_tick,
	input wire logic [1:0] word_len,
	input wire logic two_stop,
	input wire logic rx_par_en,
	input wire logic rx_par_odd,
	input wire logic tx_par_en,
	input wire logic tx_par_odd,
	input wire logic modem_irq_enable,
	input wire logic global_irq_enable
);
	// keep only the low 5+len bits of a word
	function automatic logic [7:0] fmt_mask(input logic [7:0] d,
		input logic [1:0] len);
		fmt_mask = d & (8'hff >> (3'h3 - {1'b0, len}));
	endfunction

	// parity bit over the word for even or odd sense
	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len,
		input logic odd);
		par_bit = (^fmt_mask(d, len)) ^ odd;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for every pin input
	// six strobe and line pins, two address bits and eight data bits
	logic [15:0] pin_m_q, pin_s_q;
	logic cs_s, rd_s, wr_s, sin_s, cts_s, dsr_s;
	logic [1:0] addr_s;
	logic [7:0] din_s;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_m_q <= 16'hffff;
			pin_s_q <= 16'hffff;
		end else begin
			pin_m_q <= {cs_b, rd_b, wr_b, serial_in, cts_b, dsr_b, addr, data_in};
			pin_s_q <= pin_m_q;
		end
	end
	assign {cs_s, rd_s, wr_s, sin_s, cts_s, dsr_s, addr_s, din_s} = pin_s_q;

	////////////////////////////////////////////////////////////////////////
	// strobe edge detection on the synchronised pins
	logic rd_act, wr_act, rd_act_q, wr_act_q;
	logic rd_lead, rd_trail, wr_trail;
	logic [1:0] raddr_q, waddr_q;
	logic [7:0] wdata_q;
	assign rd_act = ~cs_s & ~rd_s;
	assign wr_act = ~cs_s & ~wr_s;
	assign rd_lead = rd_act & ~rd_act_q;
	assign rd_trail = ~rd_act & rd_act_q;
	assign wr_trail = ~wr_act & wr_act_q;

	// read address held from the leading edge, write address and data tracked while low
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_act_q <= 1'b0;
			wr_act_q <= 1'b0;
			raddr_q <= 2'h0;
			waddr_q <= 2'h0;
			wdata_q <= 8'h00;
		end else begin
			rd_act_q <= rd_act;
			wr_act_q <= wr_act;
			if (rd_lead) begin
				raddr_q <= addr_s;
			end
			if (wr_act) begin
				waddr_q <= addr_s;
				wdata_q <= din_s;
			end
		end
	end

	logic usr_trail, msr_trail, rbr_trail, tbr_write, stat_read;
	assign usr_trail = rd_trail & (raddr_q == ADDR_LINE_STATUS);
	assign msr_trail = rd_trail & (raddr_q == ADDR_MODEM_STATUS);
	assign rbr_trail = rd_trail & (raddr_q == ADDR_HOLDING);
	assign tbr_write = wr_trail & (waddr_q == ADDR_HOLDING);
	assign stat_read = rd_act_q & ((raddr_q == ADDR_LINE_STATUS) |
		(raddr_q == ADDR_MODEM_STATUS));

	////////////////////////////////////////////////////////////////////////
	// modem inputs: register image is true-high, so pins are inverted
	logic [7:0] modem_line_status;
	logic cts_prev_q, dsr_prev_q, modem_ev;
	assign modem_line_status = {6'h00, ~dsr_s, ~cts_s};
	assign modem_ev = (cts_s != cts_prev_q) | (dsr_s != dsr_prev_q);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cts_prev_q <= 1'b1;
			dsr_prev_q <= 1'b1;
		end else begin
			cts_prev_q <= cts_s;
			dsr_prev_q <= dsr_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receiver: 16x oversampling, mid-bit samples, lsb arrives first
	usb_rx_state_t rx_st_q;
	logic [3:0] rx_tk_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_par_q, rx_allz_q, rx_mid, rx_end_char;
	logic [7:0] rx_word;
	logic fifo_in_ready, fifo_out_valid, hold_full_q;
	logic [7:0] fifo_out_data, receive_holding_q;
	assign rx_mid = baud_tick & (rx_tk_q == TICKS_HALF);
	assign rx_end_char = (rx_st_q == RX_STOP) & rx_mid;
	// shifted in from the top, so slide down to justify at bit 0
	assign rx_word = rx_sh_q >> (3'h3 - {1'b0, word_len});

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_q <= RX_IDLE;
			rx_tk_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_par_q <= 1'b0;
			rx_allz_q <= 1'b1;
		end else begin
			if (baud_tick && rx_st_q != RX_IDLE) begin
				rx_tk_q <= rx_tk_q + 4'h1;
			end
			unique case (rx_st_q)
				RX_IDLE: begin
					rx_tk_q <= 4'h0;
					if (!sin_s) begin
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					// a start shorter than half a bit is a glitch
					if (rx_mid) begin
						rx_tk_q <= TICKS_HALF + 4'h1;
						rx_bit_q <= 3'h0;
						rx_allz_q <= 1'b1;
						rx_st_q <= sin_s ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_mid) begin
						rx_sh_q <= {sin_s, rx_sh_q[7:1]};
						rx_allz_q <= rx_allz_q & ~sin_s;
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == {1'b1, word_len}) begin
							rx_st_q <= rx_par_en ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (rx_mid) begin
						rx_par_q <= sin_s;
						rx_allz_q <= rx_allz_q & ~sin_s;
						rx_st_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					// a low line after a break must rise before a new start
					if (rx_mid) begin
						rx_st_q <= sin_s ? RX_IDLE : RX_WAIT_HIGH;
					end
				end
				RX_WAIT_HIGH: begin
					if (sin_s) begin
						rx_st_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// status events of the character, all at the stop sample
	logic ev_ovr, ev_frm, ev_par, ev_brk;
	assign ev_ovr = rx_end_char & ~fifo_in_ready;
	assign ev_frm = rx_end_char & ~sin_s;
	assign ev_par = rx_end_char & rx_par_en &
		(rx_par_q != par_bit(rx_word, word_len, rx_par_odd));
	assign ev_brk = rx_end_char & rx_allz_q & ~sin_s;

	// characters queue here while the holding is still unread
	usb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(rx_end_char),
		.in_ready(fifo_in_ready),
		.in_data(rx_word),
		.out_valid(fifo_out_valid),
		.out_ready(~hold_full_q),
		.out_data(fifo_out_data)
	);

	// receive holding is loaded in parallel and freed by a host read
	logic ev_ready;
	assign ev_ready = fifo_out_valid & ~hold_full_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_full_q <= 1'b0;
			receive_holding_q <= 8'h00;
		end else begin
			if (ev_ready) begin
				hold_full_q <= 1'b1;
				receive_holding_q <= fifo_out_data;
			end else if (rbr_trail) begin
				hold_full_q <= 1'b0;
			end
		end
	end
	assign rx_data_ready = hold_full_q;

	////////////////////////////////////////////////////////////////////////
	// transmitter: holding register feeding a framed shift register
	logic [7:0] transmit_holding_q;
	logic tx_full_q, tx_busy_q, tx_load, ev_done;
	logic [11:0] tx_shift_reg_q;
	logic [3:0] tx_left_q, tx_tk_q;
	assign tx_load = tx_full_q & ~tx_busy_q & ~cts_s;
	assign ev_done = tx_busy_q & baud_tick & (tx_tk_q == TICKS_LAST) &
		(tx_left_q == 4'h1) & ~tx_full_q & ~tbr_write;

	// a write while still full replaces the waiting character
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_full_q <= 1'b0;
			transmit_holding_q <= 8'h00;
		end else begin
			if (tbr_write) begin
				tx_full_q <= 1'b1;
				transmit_holding_q <= fmt_mask(wdata_q, word_len);
			end else if (tx_load) begin
				tx_full_q <= 1'b0;
			end
		end
	end
	assign tx_holding_empty = ~tx_full_q;

	// frame built lsb first: start, data, optional parity, stop bits
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_busy_q <= 1'b0;
			tx_shift_reg_q <= 12'hfff;
			tx_left_q <= 4'h0;
			tx_tk_q <= 4'h0;
		end else begin
			if (tx_load) begin
				tx_busy_q <= 1'b1;
				tx_tk_q <= 4'h0;
				tx_left_q <= 4'h7 + {2'h0, word_len} + {3'h0, tx_par_en} +
					{3'h0, two_stop};
				tx_shift_reg_q <= ({3'h7, 8'hff, 1'b0} &
					~({3'h0, 8'hff, 1'b0} >> (3'h3 - {1'b0, word_len}))) |
					{3'h0, transmit_holding_q, 1'b0};
				if (tx_par_en) begin
					tx_shift_reg_q[4'h6 + {2'h0, word_len}] <=
						par_bit(transmit_holding_q, word_len, tx_par_odd);
				end
			end else if (tx_busy_q && baud_tick) begin
				// cts is only checked at load, so a frame always finishes
				tx_tk_q <= tx_tk_q + 4'h1;
				if (tx_tk_q == TICKS_LAST) begin
					tx_shift_reg_q <= {1'b1, tx_shift_reg_q[11:1]};
					tx_left_q <= tx_left_q - 4'h1;
					if (tx_left_q == 4'h1) begin
						tx_busy_q <= 1'b0;
					end
				end
			end
		end
	end

	// idle line is high; the output is a flop for a clean edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			serial_out <= 1'b1;
		end else begin
			serial_out <= tx_busy_q ? tx_shift_reg_q[0] : 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// line_status: sets wait out a status read, then merge at trailing edge
	logic [7:0] line_status_q, pend_q, snap_q, ev_all, pend_all;
	assign ev_all = {ev_ready, tx_load, ev_done, modem_ev, ev_brk, ev_ovr,
		ev_frm, ev_par};
	assign pend_all = pend_q | ev_all;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			line_status_q <= LINE_STATUS_RST;
			pend_q <= 8'h00;
			snap_q <= 8'h00;
		end else begin
			if (rd_lead) begin
				// an event in the leading cycle is missing from the snapshot
				snap_q <= line_status_q;
				pend_q <= ev_all;
			end else if (stat_read && !rd_trail) begin
				pend_q <= pend_all;
			end
			if (usr_trail) begin
				line_status_q <= pend_all & ~snap_q;
			end else if (msr_trail) begin
				// recurring bits clear, untouched bits stay, new bits set
				line_status_q <= (line_status_q & ~pend_all) |
					(pend_all & ~snap_q);
			end else if (!stat_read) begin
				line_status_q <= line_status_q | ev_all;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge latches: rising flags and modem changes; the request flags are kept out
	logic [7:0] stat_prev_q, edge_q, rise;
	assign rise = line_status_q & ~stat_prev_q & IRQ_PLAIN_MASK;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_prev_q <= LINE_STATUS_RST;
			edge_q <= EDGE_LATCH_RST;
		end else begin
			stat_prev_q <= line_status_q;
			// a new rise wins over the clear of the same cycle
			edge_q <= (usr_trail ? 8'h00 : msr_trail ?
				(edge_q & ~(8'h01 << ST_MODEM)) : edge_q) |
				rise | ({7'h00, modem_ev} << ST_MODEM);
		end
	end

	// interrupt: modem term masked, everything under the global enable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= global_irq_enable & (
				|(edge_q & IRQ_PLAIN_MASK & ~(8'h01 << ST_MODEM)) |
				(edge_q[ST_MODEM] & modem_irq_enable));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data latched at the leading edge, driven while the strobe lasts
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_out <= 8'h00;
		end else if (rd_lead) begin
			unique case (addr_s)
				ADDR_HOLDING: data_out <= receive_holding_q;
				ADDR_LINE_STATUS: data_out <= line_status_q;
				ADDR_MODEM_STATUS: data_out <= modem_line_status;
				default: data_out <= 8'h00;
			endcase
		end
	end
	assign data_oe = rd_act_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
		!global_irq_enable |=> !irq_out) else $error("irq while disabled");
	chk_msr_invert: assert property (@(posedge clk) disable iff (!rst_b)
		rd_lead && addr_s == ADDR_MODEM_STATUS |=>
		data_out[1:0] == ~{$past(dsr_s), $past(cts_s)})
		else $error("msr not inverted");
	chk_ready_pin: assert property (@(posedge clk) disable iff (!rst_b)
		ev_ready |=> rx_data_ready && line_status_q[ST_READY] || stat_read)
		else $error("ready not shown");
	chk_tbe_pin: assert property (@(posedge clk) disable iff (!rst_b)
		tx_load && !tbr_write |=> tx_holding_empty) else $error("tbe pin");
	chk_cts_block: assert property (@(posedge clk) disable iff (!rst_b)
		!tx_busy_q && cts_s |=> !tx_busy_q) else $error("sent without cts");
	chk_usr_clear: assert property (@(posedge clk) disable iff (!rst_b)
		usr_trail && pend_all == 8'h00 |=> line_status_q == 8'h00 &&
		!edge_q[ST_PARITY]) else $error("status not cleared");
	chk_read_hold: assert property (@(posedge clk) disable iff (!rst_b)
		stat_read && !rd_trail && !rd_lead |=> $stable(line_status_q))
		else $error("flag set during read");
	chk_overrun: assert property (@(posedge clk) disable iff (!rst_b)
		ev_ovr && !stat_read |=> line_status_q[ST_OVERRUN])
		else $error("overrun lost");
	chk_no_req_irq: assert property (@(posedge clk) disable iff (!rst_b)
		edge_q == 8'h00 |=> !irq_out) else $error("request flags raised irq");
endmodule // usb_core

// file: tb/usb_modem_model.sv
// serial modem partner: sends framed characters and holds the modem lines
// assumes baud ticks every second clock, so one bit lasts BIT_CYC clocks
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module usb_modem_model #(
	parameter int BIT_CYC = 32
) (
	// clock
	input wire logic clk,
	// serial and modem lines
	output logic serial_in,
	output logic cts_b,
	output logic dsr_b
);
	// line idles at mark, as a pulled-up wire would
	initial begin
		serial_in = 1'b1;
		// both lines start deasserted, matching the synchroniser reset
		cts_b = 1'b1;
		dsr_b = 1'b1;
	end

	// one bit cell, changed just after an edge
	task automatic bit_out(input logic v);
		serial_in <= v;
		repeat (BIT_CYC) @(posedge clk);
	endtask

	// start, n data bits lsb first, optional parity, one stop, idle cell
	task automatic send(input logic [7:0] d, input int n, input bit pe,
		input logic p, input logic stop);
		bit_out(1'b0);
		for (int k = 0; k < n; k++) begin
			bit_out(d[k]);
		end
		if (pe) begin
			bit_out(p);
		end
		bit_out(stop);
		bit_out(1'b1);
	endtask

	// modem lines change together just after an edge
	task automatic pins(input logic c, input logic d);
		@(posedge clk);
		cts_b <= c;
		dsr_b <= d;
	endtask
endmodule // usb_modem_model

// file: tb/tb_top.sv
// self-checking bench for the transceiver status and buffering block
// assumes the modem model in its own file; baud tick every second clock
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module tb_top;
	import usb_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, cs_b = 1'b1, rd_b = 1'b1, wr_b = 1'b1;
	logic [1:0] addr = 2'h0, word_len = 2'h3;
	logic [7:0] data_in = 8'h00, data_out, s;
	logic data_oe, rx_data_ready, tx_holding_empty, irq_out, serial_out;
	logic serial_in, cts_b, dsr_b, baud_tick = 1'b0, two_stop = 1'b0;
	logic rx_par_en = 1'b0, rx_par_odd = 1'b0, tx_par_en = 1'b0;
	logic tx_par_odd = 1'b0, modem_irq_enable = 1'b0;
	logic global_irq_enable = 1'b0;
	int err_total = 0, tests_run = 0;

	// clock and a 16x tick at half the clock rate
	always #5 clk = ~clk;
	always @(posedge clk) baud_tick <= ~baud_tick;

	// small queue so overrun is reached in a few characters
	usb_core #(.FIFO_DEPTH(2)) u_dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
		.rd_b(rd_b), .wr_b(wr_b), .addr(addr), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .rx_data_ready(rx_data_ready),
		.tx_holding_empty(tx_holding_empty), .irq_out(irq_out),
		.serial_in(serial_in), .serial_out(serial_out), .cts_b(cts_b),
		.dsr_b(dsr_b), .baud_tick(baud_tick), .word_len(word_len),
		.two_stop(two_stop), .rx_par_en(rx_par_en), .rx_par_odd(rx_par_odd),
		.tx_par_en(tx_par_en), .tx_par_odd(tx_par_odd),
		.modem_irq_enable(modem_irq_enable),
		.global_irq_enable(global_irq_enable));
	usb_modem_model u_modem (.clk(clk), .serial_in(serial_in), .cts_b(cts_b),
		.dsr_b(dsr_b));

	////////////////////////////////////////////////////////////////////////
	// verdict and checks
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// strobes held five clocks, so the synchronised strobe is well settled
	task automatic cpu_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		cs_b <= 1'b0;
		rd_b <= 1'b0;
		repeat (5) @(posedge clk);
		d = data_out;
		cs_b <= 1'b1;
		rd_b <= 1'b1;
		repeat (5) @(posedge clk);
	endtask

	task automatic cpu_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		data_in <= d;
		cs_b <= 1'b0;
		wr_b <= 1'b0;
		repeat (5) @(posedge clk);
		cs_b <= 1'b1;
		wr_b <= 1'b1;
		repeat (5) @(posedge clk);
	endtask

	// bounded wait on ready (sel 0) or the serial output (sel 1)
	task automatic wait_lvl(input bit sel, input logic v);
		int n;
		n = 0;
		while (((sel ? serial_out : rx_data_ready) !== v) && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) begin
			err_total++;
			$display("mismatch wait expected %h", v);
			close_out();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		chk("pins", {tx_holding_empty, rx_data_ready, irq_out, serial_out},
			8'h09);
		cpu_rd(ADDR_LINE_STATUS, s);
		chk("status rst", s, LINE_STATUS_RST);
		cpu_rd(ADDR_LINE_STATUS, s);
		chk("status clr", s, 8'h00);
		chk("tbe pin", {7'h0, tx_holding_empty}, 8'h01);
	endtask

	task automatic t_rx();
		u_modem.send(8'ha5, 8, 0, 1'b0, 1'b1);
		wait_lvl(0, 1'b1);
		cpu_rd(ADDR_LINE_STATUS, s);
		chk("ready flag", s & 8'h8f, 8'h80);
		cpu_rd(ADDR_HOLDING, s);
		chk("rx 8 bit", s, 8'ha5);
		word_len <= 2'h0;
		u_modem.send(8'hff, 5, 0, 1'b0, 1'b1);
		wait_lvl(0, 1'b1);
		cpu_rd(ADDR_HOLDING, s);
		chk("rx 5 bit", s, 8'h1f);
		chk("ready pin", {7'h0, rx_data_ready}, 8'h00);
		word_len <= 2'h3;
	endtask

	// parity, framing and break, each judged on its own character
	task automatic t_err(input bit pe, input logic [7:0] d, input logic stop,
		input logic [7:0] m);
		rx_par_en <= pe;
		u_modem.send(d, 8, pe, ~^d, stop);
		wait_lvl(0, 1'b1);
		repeat (4) @(posedge clk);
		chk("irq", {7'h0, irq_out}, {7'h0, global_irq_enable});
		cpu_rd(ADDR_LINE_STATUS, s);
		chk("err flag", s & m, m);
		cpu_rd(ADDR_HOLDING, s);
		chk("irq clr", {7'h0, irq_out}, 8'h00);
		rx_par_en <= 1'b0;
	endtask

	task automatic t_modem();
		modem_irq_enable <= 1'b1;
		u_modem.pins(1'b0, 1'b0);
		repeat (8) @(posedge clk);
		chk("modem irq", {7'h0, irq_out}, 8'h01);
		cpu_rd(ADDR_MODEM_STATUS, s);
		chk("modem st", s, 8'h03);
		chk("modem read", {7'h0, irq_out}, 8'h00);
		cpu_rd(ADDR_LINE_STATUS, s);
		chk("modem flag", s & 8'h10, 8'h10);
		modem_irq_enable <= 1'b0;
		u_modem.pins(1'b0, 1'b1);
		repeat (8) @(posedge clk);
		chk("modem mask", {7'h0, irq_out}, 8'h00);
		cpu_rd(ADDR_MODEM_STATUS, s);
		chk("modem st2", s, 8'h01);
		cpu_rd(ADDR_LINE_STATUS, s);
		chk("modem flag2", s & 8'h10, 8'h10);
	endtask

	task automatic t_tx();
		u_modem.pins(1'b1, 1'b1);
		cpu_wr(ADDR_HOLDING, 8'h3c);
		chk("tbe full", {7'h0, tx_holding_empty}, 8'h00);
		for (int k = 0; k < 200; k++) begin
			@(posedge clk);
			if (serial_out !== 1'b1) begin
				chk("cts hold", {7'h0, serial_out}, 8'h01);
				break;
			end
		end
		u_modem.pins(1'b0, 1'b1);
		wait_lvl(1, 1'b0);
		repeat (16) @(posedge clk);
		for (int k = 0; k < 8; k++) begin
			repeat (32) @(posedge clk);
			s[k] = serial_out;
		end
		chk("tx byte", s, 8'h3c);
		repeat (80) @(posedge clk);
		cpu_rd(ADDR_LINE_STATUS, s);
		chk("tx done", s & 8'h60, 8'h60);
		chk("tbe pin2", {7'h0, tx_holding_empty}, 8'h01);
	endtask

	task automatic t_overrun();
		for (int k = 0; k < 4; k++) begin
			u_modem.send(8'h10 + k[7:0], 8, 0, 1'b0, 1'b1);
		end
		cpu_rd(ADDR_LINE_STATUS, s);
		chk("overrun", s & 8'h04, 8'h04);
		cpu_rd(ADDR_HOLDING, s);
		chk("first kept", s, 8'h10);
		for (int k = 0; k < 4 && rx_data_ready === 1'b1; k++) begin
			cpu_rd(ADDR_HOLDING, s);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_rx();
		t_err(1, 8'h37, 1'b1, 8'h01);
		global_irq_enable <= 1'b1;
		t_err(0, 8'h5a, 1'b0, 8'h02);
		t_err(0, 8'h00, 1'b0, 8'h08);
		t_modem();
		global_irq_enable <= 1'b0;
		t_tx();
		t_overrun();
		close_out();
	end
endmodule // tb_top
